// File: acs_regs.svh
// Control word layout, reset values and timing counts for the converter control block
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// ==========================================================
// Control word fields
`define ACS_CTRL_W 12
`define ACS_CTRL_RST 12'h000
`define ACS_PWR_HI 11
`define ACS_PWR_LO 10
`define ACS_CODING_BIT 9
`define ACS_REFSEL_BIT 8
`define ACS_CHAN_HI 7
`define ACS_CHAN_LO 5
`define ACS_INCFG_HI 4
`define ACS_INCFG_LO 3
`define ACS_MASKSEL_BIT 2
`define ACS_CHAIN_BIT 1
`define ACS_RANGE_BIT 0
`define ACS_MASK_RST 8'h00

// ==========================================================
// Wake-up times and cycle counts at 100 MHz
`define ACS_CLK_MHZ 100
`define ACS_WAKE_INT_US 7
`define ACS_WAKE_EXT_NS 600
`define ACS_WAKE_INT_CYC (`ACS_WAKE_INT_US * `ACS_CLK_MHZ)
`define ACS_WAKE_EXT_CYC ((`ACS_WAKE_EXT_NS * `ACS_CLK_MHZ) / 1000)

`endif

// File: acs_pkg.sv
// Types shared by the converter control block
`default_nettype none
package acs_pkg;
  typedef enum logic [1:0] {
    ACS_PWR_NORMAL = 2'h0,
    ACS_PWR_AUTO_OFF = 2'h1,
    ACS_PWR_AUTO_STBY = 2'h2,
    ACS_PWR_FULL_OFF = 2'h3
  } acs_pwr_e;
  typedef enum logic [1:0] {
    ACS_IN_SINGLE = 2'h0,
    ACS_IN_PSEUDO4 = 2'h1,
    ACS_IN_DIFF = 2'h2,
    ACS_IN_PSEUDO7 = 2'h3
  } acs_incfg_e;
endpackage
`default_nettype wire

// File: acs_ctrl.sv
// Converter control: control word, sequence mask, input mux and power sequencing
//
// Contract
// RL1 - Power code 00 keeps everything powered
// RL2 - Code 01 powers fully down after conversion
// RL3 - Code 10 standby; wakes 7 us/600 ns
// RL4 - Code 11 powers down, control word kept
// RL5 - Single-ended: channel positive, negative analog ground
// RL6 - Differential pairs; odd address swaps polarity
// RL7 - Pseudo pairs map like fully differential
// RL8 - Seven-input pseudo uses input 7 negative
// RL9 - No sequencing converts last written address
// RL10 - Mask-select write arms next mask load
// RL11 - Chain-only write keeps running sequence
// RL12 - Both set: channels 0 to address, wrap
// RL13 - Eight-bit write-only mask on strobe rise
// RL14 - Mask load only after arming control write
// RL15 - Host sets pair bits in pair modes
// RL16 - Enabled channels stepped ascending, then wrap
// RL17 - Sequence runs until other control write
// RL18 - Pairs sequenced only even-positive
// RL19 - Twelve-bit control word field layout
// RL20 - Control word resets to zero
// RL21 - Falling convert strobe samples and advances
// RL22 - Mask load or consecutive write restarts
// RL23 - Skip clear bits; empty mask uses address
`timescale 1ns/1ps
`default_nettype none
`include "acs_regs.svh"

module acs_ctrl #(
  parameter int unsigned WAKE_INT_CYC = `ACS_WAKE_INT_CYC,
  parameter int unsigned WAKE_EXT_CYC = `ACS_WAKE_EXT_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Parallel host bus pins
  input wire logic chip_sel_n_in,
  input wire logic write_n_in,
  input wire logic [11:0] bus_data_in,
  input wire logic sample_strobe_n_in,
  // Conversion handshake from the analog core
  input wire logic conv_done_in,
  // Input selection: one-hot, bit 8 is analog_ground
  output logic [8:0] pos_sel_out,
  output logic [8:0] neg_sel_out,
  output logic [2:0] conv_chan_out,
  output logic conv_start_out,
  // Power and settings
  output logic core_pwr_out,
  output logic ref_pwr_out,
  output logic ready_out,
  output logic coding_out,
  output logic ref_int_out,
  output logic range_out
);

  // ==========================================================
  // Elaboration checks
  if (WAKE_INT_CYC < 1 || WAKE_EXT_CYC < 1 || WAKE_INT_CYC > 65535 || WAKE_EXT_CYC > 65535) begin : g_bad_wake
    $error("wake counts out of range");
  end

  // ==========================================================
  // Pin synchronisers
  logic [1:0] cs_sync_r, wr_sync_r, cv_sync_r;
  logic [11:0] d_s1_r, d_s2_r;
  logic wr_prev_r, cv_prev_r;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cs_sync_r <= 2'h3;
      wr_sync_r <= 2'h3;
      cv_sync_r <= 2'h3;
      d_s1_r <= 12'h000;
      d_s2_r <= 12'h000;
      wr_prev_r <= 1'b1;
      cv_prev_r <= 1'b1;
    end else begin
      cs_sync_r <= {cs_sync_r[0], chip_sel_n_in};
      wr_sync_r <= {wr_sync_r[0], write_n_in};
      cv_sync_r <= {cv_sync_r[0], sample_strobe_n_in};
      d_s1_r <= bus_data_in;
      d_s2_r <= d_s1_r;
      wr_prev_r <= wr_sync_r[1] | cs_sync_r[1];
      cv_prev_r <= cv_sync_r[1];
    end
  end

  // Write taken when the qualified strobe rises; data has been stable through two stages
  logic wr_rise, cv_fall;
  assign wr_rise = !wr_prev_r && (wr_sync_r[1] | cs_sync_r[1]);
  assign cv_fall = cv_prev_r && !cv_sync_r[1]; // [RL21]

  // ==========================================================
  // Control word, mask and sequencer state
  logic [11:0] ctrl_r, ctrl_nxt;
  logic [7:0] mask_r, mask_nxt;
  logic armed_r, armed_nxt;
  logic seq_on_r, seq_on_nxt;
  logic consec_r, consec_nxt;
  logic [2:0] pos_r, pos_nxt;
  logic [2:0] chan_r, chan_nxt;
  logic start_r, start_nxt;

  logic [2:0] addr;
  acs_pkg::acs_incfg_e incfg;
  assign addr = ctrl_r[`ACS_CHAN_HI:`ACS_CHAN_LO];
  assign incfg = acs_pkg::acs_incfg_e'(ctrl_r[`ACS_INCFG_HI:`ACS_INCFG_LO]);

  // Enabled set for the running sequence
  logic [7:0] eff_mask;
  logic pair_mode;
  assign pair_mode = (incfg == acs_pkg::ACS_IN_DIFF) || (incfg == acs_pkg::ACS_IN_PSEUDO4);
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_en
      logic base;
      assign base = consec_r ? (3'(gi) <= addr) : mask_r[gi]; // [RL12]
      // Odd members of a pair are never picked by the sequence; pair picked by its even bit
      assign eff_mask[gi] = pair_mode ? (((gi % 2) == 0) && base) : base; // [RL18]
    end
  endgenerate

  // Next enabled channel at or after a start index, wrapping
  function automatic logic [3:0] next_en(input logic [7:0] m, input logic [2:0] from);
    logic [3:0] res;
    logic [2:0] idx;
    res = 4'h8;
    for (int k = 7; k >= 0; k--) begin
      idx = 3'(from + 3'(k));
      if (m[idx]) begin
        res = {1'b0, idx};
      end
    end
    return res;
  endfunction

  logic [3:0] pick;
  assign pick = next_en(eff_mask, pos_r);

  always_comb begin
    ctrl_nxt = ctrl_r;
    mask_nxt = mask_r;
    armed_nxt = armed_r;
    seq_on_nxt = seq_on_r;
    consec_nxt = consec_r;
    pos_nxt = pos_r;
    chan_nxt = chan_r;
    start_nxt = 1'b0;
    if (wr_rise) begin
      if (armed_r) begin
        mask_nxt = d_s2_r[7:0]; // [RL10] [RL13] [RL14]
        armed_nxt = 1'b0;
        seq_on_nxt = 1'b1;
        consec_nxt = 1'b0;
        pos_nxt = 3'h0; // [RL22]
      end else begin
        ctrl_nxt = d_s2_r; // [RL19] [RL4]
        unique case ({d_s2_r[`ACS_CHAIN_BIT], d_s2_r[`ACS_MASKSEL_BIT]})
          2'b00: begin
            seq_on_nxt = 1'b0; // [RL9] [RL17]
            consec_nxt = 1'b0;
          end
          2'b01: begin
            armed_nxt = 1'b1; // [RL10]
            seq_on_nxt = 1'b0;
            consec_nxt = 1'b0;
          end
          2'b10: begin
            seq_on_nxt = seq_on_r; // [RL11]
          end
          default: begin
            seq_on_nxt = 1'b1; // [RL12]
            consec_nxt = 1'b1;
            pos_nxt = 3'h0; // [RL22]
          end
        endcase
      end
    end else if (cv_fall) begin
      start_nxt = 1'b1;
      if (seq_on_r && !pick[3]) begin
        chan_nxt = pick[2:0]; // [RL16]
        pos_nxt = 3'(pick[2:0] + 3'h1);
      end else begin
        chan_nxt = addr; // [RL9] [RL23]
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_r <= `ACS_CTRL_RST; // [RL20]
      mask_r <= `ACS_MASK_RST;
      armed_r <= 1'b0;
      seq_on_r <= 1'b0;
      consec_r <= 1'b0;
      pos_r <= 3'h0;
      chan_r <= 3'h0;
      start_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      mask_r <= mask_nxt;
      armed_r <= armed_nxt;
      seq_on_r <= seq_on_nxt;
      consec_r <= consec_nxt;
      pos_r <= pos_nxt;
      chan_r <= chan_nxt;
      start_r <= start_nxt;
    end
  end

  // ==========================================================
  // Input selection, registered
  logic [8:0] pos_nx, neg_nx;
  logic [8:0] pos_q_r, neg_q_r;
  always_comb begin
    pos_nx = 9'h000;
    neg_nx = 9'h000;
    pos_nx[chan_r] = 1'b1;
    case (incfg)
      acs_pkg::ACS_IN_SINGLE: neg_nx[8] = 1'b1; // [RL5]
      acs_pkg::ACS_IN_DIFF, acs_pkg::ACS_IN_PSEUDO4: neg_nx[chan_r ^ 3'h1] = 1'b1; // [RL6] [RL7]
      default: neg_nx[7] = 1'b1; // [RL8]
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pos_q_r <= 9'h001;
      neg_q_r <= 9'h100;
    end else begin
      pos_q_r <= pos_nx;
      neg_q_r <= neg_nx;
    end
  end

  // ==========================================================
  // Power sequencing
  typedef enum {PW_ON, PW_CONV, PW_DOWN, PW_WAKE} acs_pw_e;
  acs_pw_e pw_r, pw_nxt;
  logic [15:0] wake_r, wake_nxt;
  logic wake_conv_r, wake_conv_nxt;
  acs_pkg::acs_pwr_e pmode;
  assign pmode = acs_pkg::acs_pwr_e'(ctrl_r[`ACS_PWR_HI:`ACS_PWR_LO]);

  // Reference stays up only in standby; wake count is WAKE_INT_CYC with internal reference selected, else WAKE_EXT_CYC
  always_comb begin
    pw_nxt = pw_r;
    wake_nxt = wake_r;
    wake_conv_nxt = wake_conv_r;
    case (pw_r)
      PW_ON: begin
        if (pmode == acs_pkg::ACS_PWR_FULL_OFF) begin
          pw_nxt = PW_DOWN; // [RL4]
        end else if (start_r) begin
          pw_nxt = PW_CONV;
        end
      end
      PW_CONV: begin
        if (conv_done_in) begin
          pw_nxt = (pmode == acs_pkg::ACS_PWR_AUTO_OFF || pmode == acs_pkg::ACS_PWR_AUTO_STBY)
                   ? PW_DOWN : PW_ON; // [RL1] [RL2] [RL3]
        end
      end
      PW_DOWN: begin
        // Full shutdown ignores the convert strobe; only a control write brings it back
        if (pmode == acs_pkg::ACS_PWR_NORMAL || (start_r && pmode != acs_pkg::ACS_PWR_FULL_OFF)) begin // [RL4]
          pw_nxt = PW_WAKE;
          wake_nxt = 16'(ctrl_r[`ACS_REFSEL_BIT] ? WAKE_INT_CYC : WAKE_EXT_CYC); // [RL3]
          wake_conv_nxt = start_r;
        end
      end
      default: begin
        // A start that woke the core still owes its done, so power-down can follow it.
        // A done seen while waking leaves the core up until the next conversion.
        if (conv_done_in) begin
          wake_conv_nxt = 1'b0;
        end
        if (wake_r <= 16'h0001) begin
          pw_nxt = (wake_conv_r && !conv_done_in) ? PW_CONV : PW_ON; // [RL2] [RL3]
          wake_conv_nxt = 1'b0;
        end else begin
          wake_nxt = 16'(wake_r - 16'h0001);
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pw_r <= PW_ON;
      wake_r <= 16'h0000;
      wake_conv_r <= 1'b0;
    end else begin
      pw_r <= pw_nxt;
      wake_r <= wake_nxt;
      wake_conv_r <= wake_conv_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign pos_sel_out = pos_q_r;
  assign neg_sel_out = neg_q_r;
  assign conv_chan_out = chan_r;
  assign conv_start_out = start_r;
  assign core_pwr_out = (pw_r != PW_DOWN); // [RL1] [RL2]
  assign ref_pwr_out = (pw_r != PW_DOWN) || (pmode == acs_pkg::ACS_PWR_AUTO_STBY); // [RL3]
  assign ready_out = (pw_r == PW_ON);
  assign coding_out = ctrl_r[`ACS_CODING_BIT];
  assign ref_int_out = ctrl_r[`ACS_REFSEL_BIT];
  assign range_out = ctrl_r[`ACS_RANGE_BIT];

  // ==========================================================
  // Assertions
  a_normal_stays_on: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RL1]
    (pmode == acs_pkg::ACS_PWR_NORMAL && pw_r != PW_DOWN && pw_r != PW_WAKE) |=> core_pwr_out)
    else $error("normal mode lost power");
  a_autooff_down: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RL2]
    (pw_r == PW_CONV && conv_done_in && pmode == acs_pkg::ACS_PWR_AUTO_OFF && !wr_rise)
    |=> !core_pwr_out && !ref_pwr_out)
    else $error("auto shutdown did not power down");
  a_standby_ref: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RL3]
    (pw_r == PW_DOWN && pmode == acs_pkg::ACS_PWR_AUTO_STBY) |-> ref_pwr_out && !core_pwr_out)
    else $error("standby reference off");
  a_full_off_keep: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RL4]
    (pw_r == PW_DOWN && !wr_rise) |=> $stable(ctrl_r))
    else $error("control word changed in shutdown");
  a_single_gnd: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RL5]
    (incfg == acs_pkg::ACS_IN_SINGLE && $stable(incfg)) |=> neg_sel_out == 9'h100)
    else $error("single ended negative not ground");
  a_pair_swap: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RL6]
    (pair_mode && $stable(incfg)) |=> (neg_sel_out == (pos_sel_out[0] ? 9'h002 : pos_sel_out[1] ? 9'h001 :
    pos_sel_out[2] ? 9'h008 : pos_sel_out[3] ? 9'h004 : pos_sel_out[4] ? 9'h020 : pos_sel_out[5] ? 9'h010 :
    pos_sel_out[6] ? 9'h080 : 9'h040)))
    else $error("pair mapping wrong");
  a_seven_ref: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RL8]
    (incfg == acs_pkg::ACS_IN_PSEUDO7 && $stable(incfg)) |=> neg_sel_out == 9'h080)
    else $error("seven input negative not input 7");
  a_mask_load: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RL14]
    (wr_rise && !armed_r) |=> $stable(mask_r))
    else $error("mask loaded without arming");
  a_nonseq_addr: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RL9]
    (cv_fall && !seq_on_r && !wr_rise) |=> conv_chan_out == $past(addr) && conv_start_out)
    else $error("non sequenced channel wrong");
  a_pair_even: assert property (@(posedge clk_in) disable iff (!rstn_in) // [RL18]
    (cv_fall && seq_on_r && pair_mode && eff_mask != 8'h00 && !wr_rise) |=> !conv_chan_out[0])
    else $error("swapped pair converted");
  c_mask_seq: cover property (@(posedge clk_in) disable iff (!rstn_in) wr_rise && armed_r);
  c_consec: cover property (@(posedge clk_in) disable iff (!rstn_in) cv_fall && consec_r);
  c_wake: cover property (@(posedge clk_in) disable iff (!rstn_in) pw_r == PW_WAKE ##1 pw_r == PW_ON);

endmodule // acs_ctrl
`default_nettype wire

// File: acs_host_model.sv
// Host processor model: parallel bus writes, convert strobe and analog core completion
`timescale 1ns/1ps
`default_nettype none
module acs_host_model #(
  parameter int unsigned DONE_LAT = 3
) (
  // Clock
  input wire logic clk_in,
  // Bus toward the block
  output logic chip_sel_n_out,
  output logic write_n_out,
  output logic [11:0] bus_data_out,
  output logic sample_strobe_n_out,
  // Analog core handshake
  input wire logic conv_start_in,
  output logic conv_done_out
);
  logic [7:0] done_r = 8'h00;
  initial begin
    chip_sel_n_out = 1'b1;
    write_n_out = 1'b1;
    bus_data_out = 12'h000;
    sample_strobe_n_out = 1'b1;
  end
  // ==========================================================
  // Conversion finishes a fixed latency after its start
  always @(posedge clk_in) begin
    done_r <= {done_r[6:0], conv_start_in};
  end
  assign conv_done_out = done_r[DONE_LAT-1];
  // ==========================================================
  // One bus write; a floating bus shows the inverse so stale data is never reused
  task automatic write_word(input logic [11:0] data);
    @(posedge clk_in) #1;
    bus_data_out = data;
    chip_sel_n_out = 1'b0;
    write_n_out = 1'b0;
    repeat (4) @(posedge clk_in);
    #1 write_n_out = 1'b1;
    chip_sel_n_out = 1'b1;
    repeat (4) @(posedge clk_in);
    #1 bus_data_out = ~data;
    repeat (2) @(posedge clk_in);
    #1;
  endtask
  // One convert strobe, held until the start pulse is seen or the bound runs out
  task automatic convert(output bit ok);
    ok = 1'b0;
    @(posedge clk_in) #1 sample_strobe_n_out = 1'b0;
    for (int n = 0; n < 8 && !ok; n++) begin
      @(posedge clk_in) #1;
      ok = (conv_start_in === 1'b1);
    end
    sample_strobe_n_out = 1'b1;
    repeat (4) @(posedge clk_in);
    #1;
  endtask
endmodule // acs_host_model
`default_nettype wire

// File: acs_ctrl_tb.sv
// Self-checking testbench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module acs_ctrl_tb;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic chip_sel_n, write_n, strobe_n, conv_done, conv_start;
  logic [11:0] bus_data;
  logic [8:0] pos_sel, neg_sel;
  logic [2:0] chan;
  logic core_pwr, ref_pwr, ready, coding, ref_int, range_bit;
  int err_count = 0;
  int comparisons = 0;
  always #5 clk_in = ~clk_in;
  acs_ctrl #(.WAKE_INT_CYC(4), .WAKE_EXT_CYC(2)) acs_ctrl_inst (.clk_in(clk_in), .rstn_in(rstn_in),
    .chip_sel_n_in(chip_sel_n), .write_n_in(write_n), .bus_data_in(bus_data),
    .sample_strobe_n_in(strobe_n), .conv_done_in(conv_done), .pos_sel_out(pos_sel), .neg_sel_out(neg_sel),
    .conv_chan_out(chan), .conv_start_out(conv_start), .core_pwr_out(core_pwr), .ref_pwr_out(ref_pwr),
    .ready_out(ready), .coding_out(coding), .ref_int_out(ref_int), .range_out(range_bit));
  acs_host_model #(.DONE_LAT(5)) acs_host_model_inst (.clk_in(clk_in), .chip_sel_n_out(chip_sel_n),
    .write_n_out(write_n), .bus_data_out(bus_data), .sample_strobe_n_out(strobe_n),
    .conv_start_in(conv_start), .conv_done_out(conv_done));
  // ==========================================================
  // Helpers
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] d);
    acs_host_model_inst.write_word(d);
  endtask
  task automatic conv(input logic [2:0] exp);
    bit ok;
    acs_host_model_inst.convert(ok);
    if (!ok) begin
      err_count++;
      complete_run();
    end
    check({6'h00, chan}, {6'h00, exp});
  endtask
  // Waits for the core and ready to both reach a level, with a bound
  task automatic await_pwr(input logic lvl);
    int n;
    n = 0;
    while ({core_pwr, ready} !== {lvl, lvl}) begin
      @(posedge clk_in) #1;
      n++;
      if (n > 60) begin
        err_count++;
        complete_run();
      end
    end
  endtask
  function automatic logic [8:0] exp_neg(input logic [1:0] cfg, input logic [2:0] a);
    case (cfg)
      2'h0: return 9'h100;
      2'h3: return 9'h080;
      default: return 9'h001 << (a ^ 3'h1);
    endcase
  endfunction
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    check({pos_sel[8:1], neg_sel[8]}, 9'h001);
    check({pos_sel[0], neg_sel[7:0]}, 9'h100);
    check({chan, core_pwr, ref_pwr, ready, coding, ref_int, range_bit}, 9'h038);
  endtask
  task automatic t_mux();
    for (int c = 0; c < 4; c++) begin
      for (int a = 0; a < 8; a++) begin
        if (!(c == 3 && a == 7)) begin
          wr({4'h0, a[2:0], c[1:0], 3'h0});
          conv(a[2:0]);
          check(pos_sel, 9'h001 << a);
          check(neg_sel, exp_neg(c[1:0], a[2:0]));
        end
      end
    end
  endtask
  task automatic t_settings();
    wr(12'h301);
    check({6'h00, coding, ref_int, range_bit}, 9'h007);
    conv(3'h0);
    check({8'h00, core_pwr}, 9'h001);
  endtask
  task automatic t_consec();
    wr(12'h066);
    conv(3'h0);
    conv(3'h1);
    conv(3'h2);
    conv(3'h3);
    conv(3'h0);
    conv(3'h1);
    wr(12'h2a2);
    conv(3'h2);
    check({8'h00, coding}, 9'h001);
    wr(12'h0c0);
    conv(3'h6);
  endtask
  task automatic t_mask();
    wr(12'h004);
    wr(12'h0a4);
    conv(3'h2);
    conv(3'h5);
    conv(3'h7);
    conv(3'h2);
    wr(12'h0c0);
    wr(12'h020);
    conv(3'h1);
  endtask
  task automatic t_pair();
    wr(12'h014);
    wr(12'h00f);
    conv(3'h0);
    check(neg_sel, 9'h002);
    conv(3'h2);
    conv(3'h0);
    wr(12'h0a4);
    wr(12'h000);
    conv(3'h5);
  endtask
  task automatic t_power();
    wr(12'h400);
    conv(3'h0);
    await_pwr(1'b0);
    check({8'h00, ref_pwr}, 9'h000);
    wr(12'h800);
    conv(3'h0);
    await_pwr(1'b0);
    check({8'h00, ref_pwr}, 9'h001);
    wr(12'hf00);
    await_pwr(1'b0);
    check({7'h00, ref_pwr, coding}, 9'h001);
    wr(12'h100);
    check({7'h00, core_pwr, ready}, 9'h002);
    await_pwr(1'b1);
    check({8'h00, ref_pwr}, 9'h001);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_in);
    #1 rstn_in = 1'b1;
    t_reset();
    t_mux();
    t_settings();
    t_consec();
    t_mask();
    t_pair();
    t_power();
    complete_run();
  end
endmodule // acs_ctrl_tb
`default_nettype wire
